// File: function_code_command_control.v
// command, status and function-code control front end of the bus interface unit
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fc_control_defs.vh"
module function_code_command_control #(
  parameter CODE_W = 5
) (
  // clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // exchange bus receiver and transmitter
  input wire xb_write,
  input wire [CODE_W-1:0] xb_code,
  input wire xb_chan_select,
  input wire xb_lock_on,
  output wire xb_input_locked,
  input wire xb_tx_won,
  output reg xb_tx_send,
  output reg [CODE_W-1:0] xb_tx_code,
  output wire xb_tx_pending,
  // firmware directives
  input wire fw_update_status,
  input wire fw_status_passive,
  input wire [31:0] fw_data,
  input wire fw_set_irq,
  input wire fw_release_input,
  input wire fw_load_output,
  // control store address bus
  input wire store_ready,
  output reg store_valid,
  output reg [1:0] store_entry,
  output reg [CODE_W-1:0] store_address_bus,
  // interrupts and control lines
  output reg active_ready_irq,
  output reg passive_request_irq,
  output reg decode_bus_control,
  output reg input_request,
  output reg input_acknowledge,
  output reg input_reg_release,
  output reg enabled,
  output reg [3:0] mode
);
  // internal state, queue entries and decode terms
  reg wr_pend, input_reg_locked, in_chan, in_lock_on, grant_any, out_pend, unit_reset, bus_accept;
  reg [1:0] last_served, grant_idx, bus_target;
  reg [2:0] ld_state;
  reg [3:0] exec_req, host_load, bus_load, grant_clr;
  reg [7:0] wr_addr;
  reg [31:0] act_status, pas_status, status_word;
  reg [CODE_W-1:0] in_code, out_code;
  reg [CODE_W-1:0] aq_code [0:3];
  wire addr_phase, io_write_strobe;
  wire [3:0] cmd_op;
  wire [CODE_W-1:0] cmd_code;
  integer k;
  // zero wait states; a frozen clock stretches the data phase instead of losing it
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;
  // command decode is timed by the data phase of a selected write
  assign io_write_strobe = wr_pend & ce;
  assign cmd_op = hwdata[`CMD_OP_HI:`CMD_OP_LO];
  assign cmd_code = hwdata[CODE_W-1:0];
  assign xb_input_locked = input_reg_locked;
  assign xb_tx_pending = out_pend;
  always @*
  begin
    status_word = 32'h00000000;
    status_word[`ST_ACT_FREE] = ~exec_req[`AQ_ACT_PORT];
    status_word[`ST_PAS_FREE] = ~exec_req[`AQ_PAS_PORT];
    status_word[`ST_ACT_IRQ] = active_ready_irq;
    status_word[`ST_PAS_IRQ] = passive_request_irq;
    status_word[`ST_LOCKED] = input_reg_locked;
    status_word[`ST_ENABLED] = enabled;
    status_word[`ST_IN_REQ] = input_request;
    status_word[`ST_IN_ACK] = input_acknowledge;
    status_word[`ST_MODE_LO+3:`ST_MODE_LO] = mode;
    status_word[`ST_OUT_PEND] = out_pend;
  end
  // host command decode
  always @*
  begin
    host_load = 4'h0;
    unit_reset = 1'b0;
    if (io_write_strobe && wr_addr == `OFF_CMD)
    begin
      // a load into a busy register is dropped; the host must poll the free bits
      if (cmd_op == `OP_LOAD_ACT && !exec_req[`AQ_ACT_PORT])
        host_load[`AQ_ACT_PORT] = 1'b1;
      if (cmd_op == `OP_LOAD_PAS && !exec_req[`AQ_PAS_PORT])
        host_load[`AQ_PAS_PORT] = 1'b1;
      if (cmd_op == `OP_RESET)
        unit_reset = 1'b1;
    end
    if (ld_state == `LD_DECIDE && !in_chan && in_lock_on && in_code == `XCMD_RESET)
      unit_reset = 1'b1;
  end
  // loader acceptance of an exchange bus code
  always @*
  begin
    bus_target = in_chan ? `AQ_ACT_BUS : `AQ_PAS_BUS;
    bus_accept = 1'b0;
    bus_load = 4'h0;
    if (ld_state == `LD_DECIDE && !(!in_chan && in_lock_on) && enabled
        && !exec_req[bus_target])
    begin
      bus_accept = 1'b1;
      bus_load[bus_target] = 1'b1;
    end
  end
  // rotating arbiter: search starts just after the last served entry
  always @*
  begin
    grant_any = 1'b0;
    grant_idx = last_served;
    for (k = 4; k >= 1; k = k - 1)
    begin
      if (exec_req[last_served + k[1:0]])
      begin
        grant_any = 1'b1;
        grant_idx = last_served + k[1:0];
      end
    end
    grant_clr = 4'h0;
    if (grant_any && store_ready && ce)
      grant_clr[grant_idx] = 1'b1;
  end
  // ahb address and data phases
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= haddr[7:0];
      if (addr_phase && !hwrite)
      begin
        // read data only for selected reads; unmapped addresses read zero
        if (haddr[7:0] == `OFF_STATUS)
          hrdata <= status_word;
        else if (haddr[7:0] == `OFF_ACT_STAT)
          hrdata <= act_status;
        else if (haddr[7:0] == `OFF_PAS_STAT)
          hrdata <= pas_status;
        else if (haddr[7:0] == `OFF_OUT_CODE)
          hrdata <= {{(32-CODE_W){1'b0}}, out_code};
        else
          hrdata <= 32'h00000000;
      end
      else
        hrdata <= 32'h00000000;
    end
  end
  // mode, enable and interrupt lines
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode <= `RST_MODE;
      enabled <= `RST_ENABLED;
      active_ready_irq <= 1'b0;
      passive_request_irq <= 1'b0;
      act_status <= 32'h00000000;
      pas_status <= 32'h00000000;
    end
    else if (ce)
    begin
      if (io_write_strobe && wr_addr == `OFF_CMD)
      begin
        if (cmd_op == `OP_SET_MODE)
          mode <= hwdata[3:0];
        if (cmd_op == `OP_ENABLE)
          enabled <= 1'b1;
        if (cmd_op == `OP_DISABLE)
          enabled <= 1'b0;
        if (cmd_op == `OP_CLR_ACT_IRQ)
          active_ready_irq <= 1'b0;
        if (cmd_op == `OP_CLR_PAS_IRQ)
          passive_request_irq <= 1'b0;
      end
      if (ld_state == `LD_DECIDE && !in_chan && in_lock_on)
      begin
        if (in_code == `XCMD_ENABLE)
          enabled <= 1'b1;
        if (in_code == `XCMD_DISABLE)
          enabled <= 1'b0;
      end
      if (unit_reset)
      begin
        active_ready_irq <= 1'b0;
        passive_request_irq <= 1'b0;
      end
      // a set in the same cycle as a clear wins
      if (fw_set_irq && fw_data[0])
        active_ready_irq <= 1'b1;
      if (fw_set_irq && fw_data[1])
        passive_request_irq <= 1'b1;
      if (fw_update_status && !fw_status_passive)
        act_status <= fw_data;
      if (fw_update_status && fw_status_passive)
        pas_status <= fw_data;
    end
  end
  // exchange bus receiver: input register, lock and request
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      input_reg_locked <= 1'b0;
      in_code <= {CODE_W{1'b0}};
      in_chan <= 1'b0;
      in_lock_on <= 1'b0;
      input_request <= 1'b0;
    end
    else if (ce)
    begin
      if (input_reg_release)
        input_reg_locked <= 1'b0;
      else if (xb_write && !input_reg_locked)
      begin
        in_code <= xb_code;
        in_chan <= xb_chan_select;
        in_lock_on <= xb_lock_on;
        input_reg_locked <= 1'b1;
        input_request <= 1'b1;
      end
      else if (input_acknowledge)
        input_request <= 1'b0;
    end
  end
  // address queue loader
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ld_state <= `LD_IDLE;
      input_acknowledge <= 1'b0;
      input_reg_release <= 1'b0;
      decode_bus_control <= 1'b0;
    end
    else if (ce)
    begin
      input_acknowledge <= input_request;
      decode_bus_control <= 1'b0;
      case (ld_state)
        `LD_IDLE:
          if (input_acknowledge && !input_request)
            ld_state <= `LD_DECIDE;
        `LD_DECIDE:
          if (!in_chan && in_lock_on)
          begin
            decode_bus_control <= 1'b1;
            ld_state <= `LD_REL;
          end
          else if (bus_accept)
            ld_state <= `LD_HOLD;
          else
            ld_state <= `LD_REL;
        `LD_HOLD:
          if (fw_release_input)
            ld_state <= `LD_REL;
        `LD_REL:
          if (input_reg_release && !input_reg_locked)
          begin
            input_reg_release <= 1'b0;
            ld_state <= `LD_IDLE;
          end
          else
            input_reg_release <= 1'b1;
        default:
          ld_state <= `LD_IDLE;
      endcase
    end
  end
  // per-entry code registers and execute request flags
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : aq_entry
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          aq_code[g] <= {CODE_W{1'b0}};
          exec_req[g] <= 1'b0;
        end
        else if (ce)
        begin
          if (host_load[g])
            aq_code[g] <= cmd_code;
          else if (bus_load[g])
            aq_code[g] <= in_code;
          if (host_load[g] || bus_load[g])
            exec_req[g] <= 1'b1;
          else if (grant_clr[g] || unit_reset)
            exec_req[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // multiplex switch onto the store address bus
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_served <= 2'h3;
      store_valid <= 1'b0;
      store_entry <= 2'h0;
      store_address_bus <= {CODE_W{1'b0}};
    end
    else if (ce)
    begin
      store_valid <= 1'b0;
      if (grant_any && store_ready)
      begin
        last_served <= grant_idx;
        store_valid <= 1'b1;
        store_entry <= grant_idx;
        store_address_bus <= aq_code[grant_idx];
      end
    end
  end

  // output code register
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_pend <= 1'b0;
      out_code <= {CODE_W{1'b0}};
      xb_tx_send <= 1'b0;
      xb_tx_code <= {CODE_W{1'b0}};
    end
    else if (ce)
    begin
      xb_tx_send <= 1'b0;
      if (out_pend && xb_tx_won)
      begin
        xb_tx_send <= 1'b1;
        xb_tx_code <= out_code;
      end
      // a new load in the winning cycle keeps the register pending
      if (fw_load_output)
      begin
        out_code <= fw_data[CODE_W-1:0];
        out_pend <= 1'b1;
      end
      else if ((out_pend && xb_tx_won) || unit_reset)
        out_pend <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: fc_control_defs.vh
// register offsets, field positions, command and state codes for the function-code control
`ifndef FC_CONTROL_DEFS_VH
`define FC_CONTROL_DEFS_VH
// register byte offsets
`define OFF_CMD 8'h00
`define OFF_STATUS 8'h04
`define OFF_ACT_STAT 8'h08
`define OFF_PAS_STAT 8'h0C
`define OFF_OUT_CODE 8'h10
// command word fields
`define CMD_OP_HI 15
`define CMD_OP_LO 12
`define CMD_ARG_HI 7
`define CMD_ARG_LO 0
// host command opcodes
`define OP_LOAD_ACT 4'h1
`define OP_LOAD_PAS 4'h2
`define OP_CLR_ACT_IRQ 4'h3
`define OP_CLR_PAS_IRQ 4'h4
`define OP_SET_MODE 4'h5
`define OP_ENABLE 4'h6
`define OP_DISABLE 4'h7
`define OP_RESET 4'h8
// exchange bus command codes
`define XCMD_ENABLE 5'h01
`define XCMD_DISABLE 5'h02
`define XCMD_RESET 5'h03
// status word bit positions
`define ST_ACT_FREE 0
`define ST_PAS_FREE 1
`define ST_ACT_IRQ 2
`define ST_PAS_IRQ 3
`define ST_LOCKED 4
`define ST_ENABLED 5
`define ST_IN_REQ 6
`define ST_IN_ACK 7
`define ST_MODE_LO 8
`define ST_OUT_PEND 12
// address queue entries
`define AQ_ACT_PORT 2'h0
`define AQ_PAS_PORT 2'h1
`define AQ_ACT_BUS 2'h2
`define AQ_PAS_BUS 2'h3
// reset values
`define RST_MODE 4'h0
`define RST_ENABLED 1'b1
// loader states
`define LD_IDLE 3'h0
`define LD_DECIDE 3'h1
`define LD_HOLD 3'h2
`define LD_REL 3'h3
`endif

// File: function_code_command_control_assertions.sv
// port assertions for the function-code control block
`timescale 1ns/1ns
`default_nettype none
module function_code_command_control_checker (
  // clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // host bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // exchange bus
  input wire logic xb_write,
  input wire logic xb_input_locked,
  input wire logic xb_tx_won,
  input wire logic xb_tx_send,
  input wire logic xb_tx_pending,
  // handshake and control lines
  input wire logic input_request,
  input wire logic input_acknowledge,
  input wire logic input_reg_release,
  input wire logic decode_bus_control,
  input wire logic active_ready_irq
);
  logic wr_dp;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a host clear acts in the cycle after its address phase
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_dp <= 1'b0;
    else
      wr_dp <= hsel & htrans[1] & hwrite & hready & ce;
  chk_lock_on_write: assert property (
    ce && xb_write && !xb_input_locked && !input_reg_release |=> xb_input_locked && input_request)
    else $error("input register not locked after write");
  chk_lock_holds: assert property (
    ce && xb_input_locked && !input_reg_release |=> xb_input_locked)
    else $error("lock dropped without release");
  chk_req_waits_ack: assert property (input_request && !input_acknowledge |=> input_request)
    else $error("request dropped before acknowledge");
  chk_req_drops: assert property (ce && input_request && input_acknowledge |=> !input_request)
    else $error("request held after acknowledge");
  chk_ack_answers: assert property (ce && $rose(input_request) |=> input_acknowledge)
    else $error("acknowledge late");
  chk_ack_drops: assert property (ce && input_acknowledge && !input_request |=> !input_acknowledge)
    else $error("acknowledge held after request fell");
  chk_release_clears: assert property (ce && input_reg_release && xb_input_locked |=> !xb_input_locked)
    else $error("release did not clear lock");
  chk_release_ends: assert property (ce && input_reg_release && !xb_input_locked |=> !input_reg_release)
    else $error("release held after unlock");
  chk_tx_sends: assert property (ce && xb_tx_pending && xb_tx_won |=> xb_tx_send)
    else $error("output code not sent on bus win");
  chk_decode_pulse: assert property (ce && decode_bus_control |=> !decode_bus_control)
    else $error("decode control longer than one cycle");
  chk_irq_stays: assert property (active_ready_irq && !wr_dp |=> active_ready_irq)
    else $error("interrupt cleared without host command");
endmodule
bind function_code_command_control function_code_command_control_checker u_chk (.hclk, .hresetn,
  .ce, .hsel, .htrans, .hwrite, .hready, .xb_write, .xb_input_locked, .xb_tx_won, .xb_tx_send,
  .xb_tx_pending, .input_request, .input_acknowledge, .input_reg_release, .decode_bus_control,
  .active_ready_irq);
`default_nettype wire

// File: remote_port_model.sv
// remote port on the exchange bus: writes codes in, wins the bus for outgoing codes
`timescale 1ns/1ns
`default_nettype none
module remote_port_model #(
  parameter CODE_W = 5
) (
  // clock
  input wire logic hclk,
  // from the block, and the win delay from the bench
  input wire logic xb_input_locked,
  input wire logic xb_tx_pending,
  input wire logic [3:0] win_delay,
  // to the block
  output logic xb_write,
  output logic [CODE_W-1:0] xb_code,
  output logic xb_chan_select,
  output logic xb_lock_on,
  output logic xb_tx_won
);
  logic [3:0] cnt;
  initial
  begin
    xb_write = 1'b0;
    xb_code = '0;
    xb_chan_select = 1'b1;
    xb_lock_on = 1'b0;
  end
  // wait_free low lets a scenario write into a locked register on purpose
  task send(input logic [CODE_W-1:0] c, input logic ch, input logic lk, input logic wait_free);
    while (wait_free && xb_input_locked !== 1'b0)
      @(posedge hclk);
    @(posedge hclk);
    xb_write <= 1'b1;
    xb_code <= c;
    xb_chan_select <= ch;
    xb_lock_on <= lk;
    @(posedge hclk);
    xb_write <= 1'b0;
    xb_code <= ~c;
    xb_chan_select <= ~ch;
    xb_lock_on <= ~lk;
  endtask
  // bus win comes a programmable number of cycles after a code is waiting
  always @(posedge hclk)
  begin
    cnt <= xb_tx_pending ? ((cnt < win_delay) ? cnt + 4'h1 : cnt) : 4'h0;
    xb_tx_won <= xb_tx_pending && cnt >= win_delay;
  end
endmodule
`default_nettype wire

// File: function_code_command_control_tb.sv
// self-checking bench for the function-code control block
`timescale 1ns/1ns
`default_nettype none
`include "fc_control_defs.vh"
module function_code_command_control_tb;
  logic hclk, hresetn, ce, hsel, hwrite, store_ready, fw_status_passive;
  logic fw_update_status, fw_set_irq, fw_release_input, fw_load_output;
  logic [31:0] haddr, hwdata, fw_data, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] win_delay;
  wire hreadyout, hresp, xb_write, xb_chan_select, xb_lock_on, xb_input_locked, xb_tx_won;
  wire xb_tx_send, xb_tx_pending, store_valid, active_ready_irq, passive_request_irq;
  wire decode_bus_control, input_request, input_acknowledge, input_reg_release, enabled;
  wire [31:0] hrdata;
  wire [4:0] xb_code, xb_tx_code, store_address_bus;
  wire [1:0] store_entry;
  wire [3:0] mode;
  int errors, checks;
  function_code_command_control u_function_code_command_control (.hclk, .hresetn, .ce, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .xb_write, .xb_code, .xb_chan_select, .xb_lock_on, .xb_input_locked, .xb_tx_won, .xb_tx_send,
    .xb_tx_code, .xb_tx_pending, .fw_update_status, .fw_status_passive, .fw_data, .fw_set_irq,
    .fw_release_input, .fw_load_output, .store_ready, .store_valid, .store_entry,
    .store_address_bus, .active_ready_irq, .passive_request_irq, .decode_bus_control,
    .input_request, .input_acknowledge, .input_reg_release, .enabled, .mode);
  remote_port_model u_remote_port_model (.hclk, .xb_input_locked, .xb_tx_pending, .win_delay,
    .xb_write, .xb_code, .xb_chan_select, .xb_lock_on, .xb_tx_won);
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task end_sim;
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    // read data is taken at the edge that ends the data phase, before it is cleared
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge hclk);
  endtask
  task cmd(input logic [3:0] op, input logic [7:0] arg);
    bus(1'b1, `OFF_CMD, {16'h0, op, 4'h0, arg});
  endtask
  task fw(input int k, input logic [31:0] d);
    @(posedge hclk);
    fw_data <= d;
    {fw_load_output, fw_release_input, fw_set_irq, fw_update_status} <= 4'h1 << k;
    @(posedge hclk);
    {fw_load_output, fw_release_input, fw_set_irq, fw_update_status} <= 4'h0;
    repeat (3) @(negedge hclk);
  endtask
  task await(input int k);
    int n;
    logic [2:0] s;
    for (n = 0; n < 30; n++)
    begin
      @(negedge hclk);
      s = {xb_tx_send, decode_bus_control, store_valid};
      if (s[k] === 1'b1)
        break;
    end
    chk("awaited pulse", 1, n < 30);
  endtask
  task t_status;
    bus(1'b0, `OFF_STATUS, 0);
    chk("status after reset", 32'h23, r);
    chk("response", 0, hresp);
    cmd(`OP_SET_MODE, 8'h0A);
    chk("mode", 4'hA, mode);
    bus(1'b0, 8'h40, 0);
    chk("unmapped read", 0, r);
    fw_status_passive <= 1'b1;
    fw(0, 32'hA5A50F0F);
    bus(1'b0, `OFF_PAS_STAT, 0);
    chk("passive status", 32'hA5A50F0F, r);
    bus(1'b0, `OFF_ACT_STAT, 0);
    chk("active status", 0, r);
  endtask
  task t_host_load;
    bus(1'b0, `OFF_STATUS, 0);
    chk("free before load", 2'b11, r[1:0]);
    cmd(`OP_LOAD_ACT, 8'h05);
    cmd(`OP_LOAD_PAS, 8'h06);
    cmd(`OP_LOAD_ACT, 8'h09);
    bus(1'b0, `OFF_STATUS, 0);
    chk("status busy", 32'hA20, r);
    store_ready <= 1'b1;
    await(0);
    chk("first entry", {`AQ_ACT_PORT, 5'h05}, {store_entry, store_address_bus});
    await(0);
    chk("second entry", {`AQ_PAS_PORT, 5'h06}, {store_entry, store_address_bus});
    bus(1'b0, `OFF_STATUS, 0);
    chk("status free", 32'hA23, r);
  endtask
  task t_bus_code;
    store_ready <= 1'b0;
    u_remote_port_model.send(5'h07, 1'b1, 1'b0, 1'b1);
    repeat (8) @(negedge hclk);
    chk("locked", 1, xb_input_locked);
    u_remote_port_model.send(5'h0A, 1'b1, 1'b0, 1'b0);
    store_ready <= 1'b1;
    await(0);
    chk("bus entry", {`AQ_ACT_BUS, 5'h07}, {store_entry, store_address_bus});
    chk("still locked", 1, xb_input_locked);
    fw(2, 0);
    chk("released", 0, xb_input_locked);
  endtask
  task t_bus_cmd;
    u_remote_port_model.send(`XCMD_DISABLE, 1'b0, 1'b1, 1'b1);
    await(1);
    repeat (6) @(negedge hclk);
    chk("disabled", 2'b00, {enabled, xb_input_locked});
    u_remote_port_model.send(`XCMD_ENABLE, 1'b1, 1'b1, 1'b1);
    repeat (12) @(negedge hclk);
    chk("active channel no command", 2'b00, {enabled, xb_input_locked});
    u_remote_port_model.send(`XCMD_ENABLE, 1'b0, 1'b1, 1'b1);
    await(1);
    repeat (6) @(negedge hclk);
    chk("enabled", 1, enabled);
    u_remote_port_model.send(`XCMD_RESET, 1'b0, 1'b1, 1'b1);
    await(1);
    repeat (6) @(negedge hclk);
    chk("after reset command", 2'b10, {enabled, xb_input_locked});
  endtask
  task t_irq;
    fw(1, 32'h3);
    chk("irqs set", 2'b11, {active_ready_irq, passive_request_irq});
    cmd(`OP_CLR_ACT_IRQ, 8'h0);
    chk("active cleared", 2'b01, {active_ready_irq, passive_request_irq});
    bus(1'b0, `OFF_STATUS, 0);
    chk("status irq", 32'hA2B, r);
    cmd(`OP_CLR_PAS_IRQ, 8'h0);
    chk("passive cleared", 2'b00, {active_ready_irq, passive_request_irq});
    fw(1, 32'h3);
    cmd(`OP_RESET, 8'h0);
    chk("unit reset", 3'b100, {enabled, active_ready_irq, passive_request_irq});
    cmd(`OP_DISABLE, 8'h0);
    chk("host disable", 0, enabled);
    cmd(`OP_ENABLE, 8'h0);
    chk("host enable", 1, enabled);
  endtask
  task t_out;
    fw(3, 32'h09);
    await(2);
    chk("slow send", 5'h09, xb_tx_code);
    @(negedge hclk);
    chk("pending cleared", 0, xb_tx_pending);
    win_delay <= 4'h1;
    fw(3, 32'h16);
    await(2);
    chk("prompt send", 5'h16, xb_tx_code);
  endtask
  task t_freeze;
    @(posedge hclk);
    ce <= 1'b0;
    fw(1, 32'h3);
    chk("frozen irqs", 2'b00, {active_ready_irq, passive_request_irq});
    chk("frozen ready", 0, hreadyout);
    @(posedge hclk);
    ce <= 1'b1;
  endtask
  initial
  begin
    #2000000;
    errors++;
    end_sim;
  end
  initial
  begin
    {hresetn, ce, hsel, hwrite, haddr, htrans, hwdata, hsize} = {2'b01, 68'h0, 3'h2};
    {fw_update_status, fw_set_irq, fw_release_input, fw_load_output} = 4'h0;
    {store_ready, fw_status_passive, fw_data, win_delay} = {2'b00, 32'h0, 4'h3};
    errors = 0;
    checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_status;
    t_host_load;
    t_bus_code;
    t_bus_cmd;
    t_irq;
    t_out;
    t_freeze;
    end_sim;
  end
endmodule
`default_nettype wire
